// file: src/dsi_target.sv
// I2C target core answering for a gas unit and a humidity/temperature unit
`timescale 1ns/1ps
module dsi_target #(
    parameter int MEAS_CYC = dsi_pkg::MEAS_MAX_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // I2C pins, open drain; SDA is driven low while sda_oe_n_out is low
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    // Command and parameter words towards the sensor units
    output logic cmd_valid_out,
    output dsi_pkg::dsi_cmd_t cmd_out,
    output logic wr_valid_out,
    output dsi_pkg::dsi_cmd_t wr_out,
    // Result words from the sensor unit that is measuring
    input wire logic res_valid_in,
    input wire dsi_pkg::dsi_word_t res_data_in,
    output logic res_ready_out,
    // Status
    output logic busy_out,
    output logic idle_out
);
    dsi_pkg::dsi_core_t s_q;
    dsi_pkg::dsi_core_t s_d;

    // Bus events seen on the sampled pins
    logic rise;
    logic fall;
    logic start;
    logic stop;

    // Decode of a finished address byte
    logic [6:0] addr;
    logic hit;
    logic hit_tgt;

    // Transmit byte selection and check byte engine
    logic in_range;
    logic [7:0] tx_next;
    logic load;
    logic [7:0] crc_seed;
    logic [7:0] crc_data;
    logic [7:0] crc_next;

    // Buffer drain side
    logic buf_valid;
    logic buf_ready;
    dsi_pkg::dsi_word_t buf_data;
    logic res_ready;

    // Results enter through the buffer so a stalled core drops no word
    dsi_buf2 u_buf (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .in_valid_in(res_valid_in),
        .in_data_in(res_data_in),
        .in_ready_out(res_ready),
        .out_valid_out(buf_valid),
        .out_data_out(buf_data),
        .out_ready_in(buf_ready)
    );

    // One check engine serves both directions; a transfer is never both at once
    dsi_crc8 u_crc (
        .crc_in(crc_seed),
        .data_in(crc_data),
        .crc_out(crc_next)
    );

    // Results are taken only while a measurement runs and the store has room
    assign buf_ready = s_q.busy & (s_q.wcnt < 3'(dsi_pkg::RES_WORDS));

    // Pick the next byte to send: MSB, LSB, then the running check byte
    always_comb begin
        in_range = (s_q.rd_word < s_q.rd_len);
        unique case (s_q.rd_phase)
            dsi_pkg::PH_MSB: tx_next = s_q.mem[s_q.rd_word[1:0]][15:8];
            dsi_pkg::PH_LSB: tx_next = s_q.mem[s_q.rd_word[1:0]][7:0];
            default: tx_next = s_q.crc;
        endcase
        if (!in_range) begin
            tx_next = dsi_pkg::FILL_BYTE;
        end
    end

    // Seed is restarted at each word boundary in both directions
    always_comb begin
        if (s_q.rd) begin
            crc_seed = (s_q.rd_phase == dsi_pkg::PH_MSB) ? dsi_pkg::CRC_INIT : s_q.crc;
            crc_data = tx_next;
        end else begin
            crc_seed = (s_q.byte_idx == dsi_pkg::BYTE_DATA_HI) ? dsi_pkg::CRC_INIT : s_q.crc;
            crc_data = s_q.shreg;
        end
    end

    // Pins are synchronous, so one stored sample is enough for edge detection
    always_comb begin
        rise = ~s_q.scl_q & scl_in;
        fall = s_q.scl_q & ~scl_in;
        start = s_q.scl_q & scl_in & s_q.sda_q & ~sda_in;
        stop = s_q.scl_q & scl_in & ~s_q.sda_q & sda_in;
        addr = s_q.shreg[7:1];
        hit = (addr == dsi_pkg::ADDR_GAS) || (addr == dsi_pkg::ADDR_RHT);
        hit_tgt = (addr == dsi_pkg::ADDR_RHT);
    end

    // Next state of the whole core
    always_comb begin
        s_d = s_q;
        load = 1'b0;
        s_d.scl_q = scl_in;
        s_d.sda_q = sda_in;
        s_d.cmd_valid = 1'b0;
        s_d.wr_valid = 1'b0;

        // Measurement timer; the sensor side normally ends it with its last word
        if (s_q.busy) begin
            s_d.tmr = s_q.tmr + 18'h0_0001;
            if (s_q.tmr == 18'(MEAS_CYC - 1)) begin
                s_d.busy = 1'b0;
                s_d.res_avail = 1'b1;
                s_d.res_tgt = s_q.busy_tgt;
            end
        end

        // Store incoming result words; the last one ends the measurement
        if (buf_valid && buf_ready) begin
            s_d.mem[s_q.wcnt[1:0]] = buf_data.data;
            s_d.wcnt = s_q.wcnt + 3'h1;
            if (buf_data.last) begin
                s_d.busy = 1'b0;
                s_d.res_avail = 1'b1;
                s_d.res_tgt = s_q.busy_tgt;
            end
        end

        if (s_q.st == dsi_pkg::ST_PWRUP) begin
            // Bus is ignored until the power-up delay has run out
            s_d.pu_cnt = s_q.pu_cnt + 13'h0001;
            if (s_q.pu_cnt == 13'(dsi_pkg::PU_CYC - 1)) begin
                s_d.st = dsi_pkg::ST_IDLE;
                s_d.idle = 1'b1;
            end
        end else if (start) begin
            // A repeated START restarts address reception at once
            s_d.st = dsi_pkg::ST_ADDR;
            s_d.bitcnt = 4'h0;
            s_d.sda_oe_n = 1'b1;
        end else if (stop) begin
            s_d.st = dsi_pkg::ST_IDLE;
            s_d.sda_oe_n = 1'b1;
        end else begin
            unique case (s_q.st)
                dsi_pkg::ST_ADDR: begin
                    if (rise) begin
                        s_d.shreg = {s_q.shreg[6:0], sda_in};
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                    end else if (fall && s_q.bitcnt == dsi_pkg::BITS_PER_BYTE) begin
                        s_d.bitcnt = 4'h0;
                        s_d.tgt = hit_tgt;
                        s_d.rd = s_q.shreg[0];
                        if (hit && !s_q.busy) begin
                            s_d.sda_oe_n = 1'b0;
                            s_d.st = dsi_pkg::ST_ADDR_ACK;
                            if (s_q.shreg[0]) begin
                                // Result is handed out once, then forgotten
                                if (s_q.res_avail && s_q.res_tgt == hit_tgt) begin
                                    s_d.rd_len = s_q.wcnt;
                                    s_d.res_avail = 1'b0;
                                end else begin
                                    s_d.rd_len = 3'h0;
                                end
                                s_d.rd_word = 3'h0;
                                s_d.rd_phase = dsi_pkg::PH_MSB;
                            end
                        end else begin
                            s_d.st = dsi_pkg::ST_SKIP;
                        end
                    end
                end
                dsi_pkg::ST_ADDR_ACK: begin
                    if (fall) begin
                        if (s_q.rd) begin
                            load = 1'b1;
                            s_d.st = dsi_pkg::ST_RD;
                        end else begin
                            s_d.sda_oe_n = 1'b1;
                            s_d.byte_idx = dsi_pkg::BYTE_CMD_HI;
                            s_d.st = dsi_pkg::ST_WR;
                        end
                    end
                end
                dsi_pkg::ST_WR: begin
                    if (rise) begin
                        s_d.shreg = {s_q.shreg[6:0], sda_in};
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                    end else if (fall && s_q.bitcnt == dsi_pkg::BITS_PER_BYTE) begin
                        s_d.bitcnt = 4'h0;
                        s_d.sda_oe_n = 1'b0;
                        s_d.st = dsi_pkg::ST_WR_ACK;
                        unique case (s_q.byte_idx)
                            dsi_pkg::BYTE_CMD_HI: begin
                                s_d.hold = s_q.shreg;
                                s_d.byte_idx = dsi_pkg::BYTE_CMD_LO;
                            end
                            dsi_pkg::BYTE_CMD_LO: begin
                                // Command word passes with its embedded check untouched
                                s_d.cmd.word = {s_q.hold, s_q.shreg};
                                s_d.cmd.tgt = s_q.tgt;
                                s_d.cmd_valid = 1'b1;
                                s_d.busy = 1'b1;
                                s_d.busy_tgt = s_q.tgt;
                                s_d.tmr = 18'h0_0000;
                                s_d.wcnt = 3'h0;
                                s_d.res_avail = 1'b0;
                                s_d.byte_idx = dsi_pkg::BYTE_DATA_HI;
                            end
                            dsi_pkg::BYTE_DATA_HI: begin
                                s_d.wr.word[15:8] = s_q.shreg;
                                s_d.crc = crc_next;
                                s_d.byte_idx = dsi_pkg::BYTE_DATA_LO;
                            end
                            dsi_pkg::BYTE_DATA_LO: begin
                                s_d.wr.word[7:0] = s_q.shreg;
                                s_d.crc = crc_next;
                                s_d.byte_idx = dsi_pkg::BYTE_CHECK;
                            end
                            dsi_pkg::BYTE_CHECK: begin
                                // A bad check byte drops the word and is not acknowledged
                                if (s_q.shreg == s_q.crc) begin
                                    s_d.wr.tgt = s_q.tgt;
                                    s_d.wr_valid = 1'b1;
                                end else begin
                                    s_d.sda_oe_n = 1'b1;
                                    s_d.st = dsi_pkg::ST_SKIP;
                                end
                                s_d.byte_idx = dsi_pkg::BYTE_DATA_HI;
                            end
                            default: begin
                                s_d.byte_idx = dsi_pkg::BYTE_DATA_HI;
                            end
                        endcase
                    end
                end
                dsi_pkg::ST_WR_ACK: begin
                    if (fall) begin
                        s_d.sda_oe_n = 1'b1;
                        s_d.st = dsi_pkg::ST_WR;
                    end
                end
                dsi_pkg::ST_RD: begin
                    if (fall) begin
                        if (s_q.bitcnt == dsi_pkg::BITS_PER_BYTE) begin
                            s_d.sda_oe_n = 1'b1;
                            s_d.st = dsi_pkg::ST_RD_ACK;
                        end else begin
                            s_d.txbyte = {s_q.txbyte[6:0], 1'b0};
                            s_d.sda_oe_n = s_q.txbyte[6];
                            s_d.bitcnt = s_q.bitcnt + 4'h1;
                        end
                    end
                end
                dsi_pkg::ST_RD_ACK: begin
                    if (rise) begin
                        s_d.shreg = {7'h00, sda_in};
                    end else if (fall) begin
                        // Master acknowledge keeps data flowing; anything else ends it
                        if (!s_q.shreg[0]) begin
                            load = 1'b1;
                            s_d.st = dsi_pkg::ST_RD;
                        end else begin
                            s_d.st = dsi_pkg::ST_SKIP;
                        end
                    end
                end
                default: begin
                    s_d.sda_oe_n = 1'b1;
                end
            endcase
        end

        // Put the first bit of a fresh byte on SDA and advance the read pointer
        if (load) begin
            s_d.txbyte = tx_next;
            s_d.sda_oe_n = tx_next[7];
            s_d.bitcnt = 4'h1;
            if (s_q.rd_phase != dsi_pkg::PH_CHECK) begin
                s_d.crc = crc_next;
            end
            // The pointer saturates so bytes past the end stay filler
            if (in_range) begin
                if (s_q.rd_phase == dsi_pkg::PH_CHECK) begin
                    s_d.rd_phase = dsi_pkg::PH_MSB;
                    s_d.rd_word = s_q.rd_word + 3'h1;
                end else begin
                    s_d.rd_phase = s_q.rd_phase + 2'h1;
                end
            end
        end
    end

    // All core state in one register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_q <= dsi_pkg::CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Ready is the buffer's own registered flag; one more stage would promise room already gone
    assign res_ready_out = res_ready;

    // Outputs straight from the state register
    assign sda_out = s_q.sda_o;
    assign sda_oe_n_out = s_q.sda_oe_n;
    assign cmd_valid_out = s_q.cmd_valid;
    assign cmd_out = s_q.cmd;
    assign wr_valid_out = s_q.wr_valid;
    assign wr_out = s_q.wr;
    assign busy_out = s_q.busy;
    assign idle_out = s_q.idle;
endmodule

// file: shared/dsi_pkg.sv
// Shared constants and types of the dual sensor I2C command target
package dsi_pkg;

    // Seven-bit bus addresses of the two sensor units
    localparam logic [6:0] ADDR_GAS = 7'h58;
    localparam logic [6:0] ADDR_RHT = 7'h70;

    // Check byte generator: polynomial, seed, and filler beyond the response
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] FILL_BYTE = 8'hff;

    // Clock rate and timing figures
    localparam int CLK_KHZ = 10000;
    localparam int PU_TYP_US = 400;
    localparam int PU_CYC = (PU_TYP_US * CLK_KHZ + 999) / 1000;
    localparam int MEAS_MAX_US = 14400;
    localparam int MEAS_MAX_CYC = (MEAS_MAX_US * CLK_KHZ) / 1000;

    // Result store depth and byte sequencing
    localparam int RES_WORDS = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] BYTE_CMD_HI = 3'h0;
    localparam logic [2:0] BYTE_CMD_LO = 3'h1;
    localparam logic [2:0] BYTE_DATA_HI = 3'h2;
    localparam logic [2:0] BYTE_DATA_LO = 3'h3;
    localparam logic [2:0] BYTE_CHECK = 3'h4;
    localparam logic [1:0] PH_MSB = 2'h0;
    localparam logic [1:0] PH_LSB = 2'h1;
    localparam logic [1:0] PH_CHECK = 2'h2;

    // Result word handed in by the sensor side
    typedef struct packed {
        logic last;
        logic [15:0] data;
    } dsi_word_t;

    // Command or parameter word handed out, with its target unit (1 = RH/T)
    typedef struct packed {
        logic tgt;
        logic [15:0] word;
    } dsi_cmd_t;

    typedef enum logic [3:0] {
        ST_PWRUP, ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_SKIP
    } dsi_state_t;

    // Whole state of the target core
    typedef struct packed {
        dsi_state_t st;
        logic scl_q;
        logic sda_q;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic tgt;
        logic rd;
        logic [2:0] byte_idx;
        logic [7:0] crc;
        logic [7:0] hold;
        logic [12:0] pu_cnt;
        logic [17:0] tmr;
        logic busy;
        logic busy_tgt;
        logic res_avail;
        logic res_tgt;
        logic [2:0] wcnt;
        logic [3:0][15:0] mem;
        logic [2:0] rd_len;
        logic [2:0] rd_word;
        logic [1:0] rd_phase;
        logic [7:0] txbyte;
        logic sda_o;
        logic sda_oe_n;
        logic cmd_valid;
        dsi_cmd_t cmd;
        logic wr_valid;
        dsi_cmd_t wr;
        logic idle;
    } dsi_core_t;

    localparam dsi_core_t CORE_RST = '{st: ST_PWRUP, scl_q: 1'b1, sda_q: 1'b1,
                                        sda_oe_n: 1'b1, default: '0};

    // State of the two-entry buffer
    typedef struct packed {
        dsi_word_t [1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic full;
    } dsi_buf_t;

    // Full while in reset, so no word is offered room before the buffer runs
    localparam dsi_buf_t BUF_RST = '{full: 1'b1, default: '0};

endpackage

// file: src/dsi_crc8.sv
// Byte-wise CRC-8 step for the word check bytes
`timescale 1ns/1ps
module dsi_crc8 (
    // Running value and new byte
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data_in,
    // Updated value
    output logic [7:0] crc_out
);
    // One shift per bit, MSB first, no final inversion
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ dsi_pkg::CRC_POLY) : {c[6:0], 1'b0};
        end
        crc_out = c;
    end
endmodule

// file: src/dsi_buf2.sv
// Two-entry buffer between the sensor result source and the target core
`timescale 1ns/1ps
module dsi_buf2 (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Filling side
    input wire logic in_valid_in,
    input wire dsi_pkg::dsi_word_t in_data_in,
    output logic in_ready_out,
    // Draining side
    output logic out_valid_out,
    output dsi_pkg::dsi_word_t out_data_out,
    input wire logic out_ready_in
);
    dsi_pkg::dsi_buf_t s_q;
    dsi_pkg::dsi_buf_t s_d;
    logic push;
    logic pop;

    // Ready comes from a registered full flag, so a push never meets a full store
    always_comb begin
        push = in_valid_in & ~s_q.full;
        pop = out_ready_in & (s_q.cnt != 2'h0);
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data_in;
            s_d.wp = ~s_q.wp;
        end
        if (pop) begin
            s_d.rp = ~s_q.rp;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
        s_d.full = (s_d.cnt == 2'h2);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_q <= dsi_pkg::BUF_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready_out = ~s_q.full;
    assign out_valid_out = (s_q.cnt != 2'h0);
    assign out_data_out = s_q.mem[s_q.rp];
endmodule

// file: test/dsi_host.sv
// Behavioural I2C master standing in for the host controller
`timescale 1ns/1ps
module dsi_host (
    // Clock and bus wire
    input wire logic clk_in,
    input wire logic sda_in,
    // Driven bus levels, high means released
    output logic scl_out,
    output logic sda_out
);
    // Idle bus at time zero
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // Each transfer opens with a start, repeated start allowed
    task automatic start();
        sda_out = 1'b1;
        tick(1);
        scl_out = 1'b1;
        tick(4);
        sda_out = 1'b0;
        tick(4);
        scl_out = 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_out = 1'b0;
        tick(3);
        scl_out = 1'b1;
        tick(4);
        sda_out = 1'b1;
        tick(4);
    endtask
    // SDA only moves while SCL is low; four clocks per phase
    task automatic bitx(input logic b, output logic r);
        sda_out = b;
        tick(3);
        scl_out = 1'b1;
        tick(2);
        r = sda_in;
        tick(2);
        scl_out = 1'b0;
        tick(1);
    endtask
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(v[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    // The caller picks the ack bit, so it may cut a read short
    task automatic rbyte(input logic ack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            v[i] = r;
        end
        bitx(~ack, r);
    endtask
endmodule

// file: test/dsi_target_assertions.sv
// Port-level assertions for the I2C target core
`timescale 1ns/1ps
module dsi_target_assertions #(
    parameter int MEAS_CYC = 1000
) (
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic scl_in,
    input wire logic sda_oe_n_out,
    // Status and pulses
    input wire logic cmd_valid_out,
    input wire logic wr_valid_out,
    input wire logic busy_out,
    input wire logic idle_out
);
    logic [31:0] busy_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // Length of the running measurement
    always_ff @(posedge clk_in) begin
        busy_q <= (srst_in || !busy_out) ? 32'h0000_0000 : busy_q + 32'h0000_0001;
    end
    sequence s_rel;
        $fell(srst_in);
    endsequence
    property p_ack_cmd;
        cmd_valid_out |-> !sda_oe_n_out && busy_out;
    endproperty
    property p_busy_rise;
        $rose(busy_out) |-> cmd_valid_out;
    endproperty
    property p_pulse;
        cmd_valid_out || wr_valid_out |=> !cmd_valid_out && !wr_valid_out;
    endproperty
    property p_quiet;
        !idle_out |-> sda_oe_n_out;
    endproperty
    property p_sticky;
        idle_out |=> idle_out;
    endproperty
    property p_pwrup;
        s_rel |-> !idle_out [*8];
    endproperty
    property p_sda_scl;
        $changed(sda_oe_n_out) |-> !scl_in;
    endproperty
    property p_meas;
        busy_q <= MEAS_CYC + 2;
    endproperty
    a_ack_cmd: assert property (p_ack_cmd) else $error("command not acked");
    a_busy_rise: assert property (p_busy_rise) else $error("busy without command");
    a_pulse: assert property (p_pulse) else $error("pulse too long");
    a_quiet: assert property (p_quiet) else $error("drive before idle");
    a_sticky: assert property (p_sticky) else $error("idle dropped");
    a_pwrup: assert property (p_pwrup) else $error("idle too early");
    a_sda_scl: assert property (p_sda_scl) else $error("sda moved with scl high");
    a_meas: assert property (p_meas) else $error("measurement overran");
endmodule
bind dsi_target dsi_target_assertions #(.MEAS_CYC(MEAS_CYC)) u_dsi_target_assertions (
    .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_in), .sda_oe_n_out(sda_oe_n_out),
    .cmd_valid_out(cmd_valid_out), .wr_valid_out(wr_valid_out), .busy_out(busy_out),
    .idle_out(idle_out));

// file: test/tb_top.sv
// Self-checking bench of the dual sensor I2C command target
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic res_v = 1'b0;
    logic scl, sda_h, sda_o, sda_oe_n, cmd_v, wr_v, res_rdy, busy, idle, a;
    wire logic sda_w;
    dsi_pkg::dsi_word_t res_d = '0;
    dsi_pkg::dsi_cmd_t cmd, wr, last_cmd, last_wr;
    logic [7:0] d;
    int fails = 0;
    int checked = 0;
    int nwr = 0;
    int n;
    // Pull-up wire: any party pulling low wins
    assign sda_w = sda_h & (sda_oe_n | sda_o);
    always #50 clk_in = ~clk_in;
    // Keep the latest command and parameter words
    always @(posedge clk_in) begin
        if (cmd_v === 1'b1)
            last_cmd <= cmd;
        if (wr_v === 1'b1) begin
            last_wr <= wr;
            nwr <= nwr + 1;
        end
    end
    dsi_target #(.MEAS_CYC(1000)) u_dsi_target (.clk_in(clk_in), .srst_in(srst_in),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
        .cmd_valid_out(cmd_v), .cmd_out(cmd), .wr_valid_out(wr_v), .wr_out(wr),
        .res_valid_in(res_v), .res_data_in(res_d), .res_ready_out(res_rdy),
        .busy_out(busy), .idle_out(idle));
    dsi_host u_dsi_host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_h));
    task automatic results();
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bitwise MSB-first check byte over one word
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = dsi_pkg::CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ dsi_pkg::CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic hdr(input logic [6:0] ad, input logic rd);
        u_dsi_host.start();
        u_dsi_host.wbyte({ad, rd}, a);
    endtask
    // Hold the word until ready stands ahead of an edge, then leave a gap clock
    task automatic push(input logic last, input logic [15:0] w);
        res_d = {last, w};
        res_v = 1'b1;
        for (int k = 0; k < 100 && res_rdy !== 1'b1; k++) begin
            @(negedge clk_in);
        end
        if (res_rdy !== 1'b1) begin
            fails++;
            results();
        end
        @(negedge clk_in);
        res_v = 1'b0;
        @(negedge clk_in);
    endtask
    task automatic wait_free(output int cnt);
        cnt = 0;
        while (busy !== 1'b0 && cnt < 20000) begin
            @(negedge clk_in);
            cnt++;
        end
        if (cnt >= 20000) begin
            fails++;
            results();
        end
    endtask
    task automatic t_pwrup();
        hdr(dsi_pkg::ADDR_RHT, 1'b1);
        u_dsi_host.stop();
        chk(a, 0);
        for (n = 0; n < 7000 && idle !== 1'b1; n++) begin
            @(negedge clk_in);
        end
        chk(n >= 3800 && n <= 6000, 1);
        $display("power-up test done");
    endtask
    task automatic t_cmd_read();
        logic [7:0] e [8];
        e = '{8'hbe, 8'hef, crc8(16'hbeef), 8'h12, 8'h34, crc8(16'h1234), 8'hff, 8'hff};
        hdr(dsi_pkg::ADDR_RHT, 1'b0);
        chk(a, 1);
        u_dsi_host.wbyte(8'h78, a);
        u_dsi_host.wbyte(8'h66, a);
        u_dsi_host.stop();
        chk({a, last_cmd}, {1'b1, 1'b1, 16'h7866});
        hdr(dsi_pkg::ADDR_RHT, 1'b1);
        u_dsi_host.stop();
        chk(a, 0);
        hdr(dsi_pkg::ADDR_GAS, 1'b1);
        u_dsi_host.stop();
        chk(a, 0);
        push(1'b0, 16'hbeef);
        push(1'b1, 16'h1234);
        wait_free(n);
        hdr(dsi_pkg::ADDR_RHT, 1'b1);
        chk(a, 1);
        for (int k = 0; k < 8; k++) begin
            u_dsi_host.rbyte(k < 7, d);
            chk(d, e[k]);
        end
        u_dsi_host.stop();
        hdr(dsi_pkg::ADDR_RHT, 1'b1);
        u_dsi_host.rbyte(1'b0, d);
        u_dsi_host.stop();
        chk(d, 8'hff);
        $display("command and read test done");
    endtask
    task automatic t_write();
        int w0;
        time t0;
        hdr(dsi_pkg::ADDR_GAS, 1'b0);
        u_dsi_host.wbyte(8'h20, a);
        u_dsi_host.wbyte(8'h61, a);
        t0 = $time;
        u_dsi_host.wbyte(8'h0f, a);
        u_dsi_host.wbyte(8'h80, a);
        u_dsi_host.wbyte(crc8(16'h0f80), a);
        chk({a, last_wr}, {1'b1, 1'b0, 16'h0f80});
        w0 = nwr;
        u_dsi_host.wbyte(8'h12, a);
        u_dsi_host.wbyte(8'h34, a);
        u_dsi_host.wbyte(~crc8(16'h1234), a);
        u_dsi_host.stop();
        chk({a, nwr == w0}, 2'b01);
        wait_free(n);
        chk(($time - t0) / 100 >= 980 && ($time - t0) / 100 <= 1000, 1);
        hdr(7'h31, 1'b0);
        u_dsi_host.stop();
        chk(a, 0);
        $display("write test done");
    endtask
    // Fill the buffer while idle, then let a measurement take one of its two words
    task automatic t_full();
        res_d = {1'b1, 16'h5a5a};
        res_v = 1'b1;
        repeat (8) @(negedge clk_in);
        chk(res_rdy, 0);
        res_v = 1'b0;
        hdr(dsi_pkg::ADDR_GAS, 1'b0);
        u_dsi_host.wbyte(8'h20, a);
        u_dsi_host.wbyte(8'h08, a);
        u_dsi_host.stop();
        wait_free(n);
        hdr(dsi_pkg::ADDR_GAS, 1'b1);
        u_dsi_host.rbyte(1'b1, d);
        chk(d, 8'h5a);
        u_dsi_host.rbyte(1'b1, d);
        u_dsi_host.rbyte(1'b0, d);
        u_dsi_host.stop();
        chk(d, crc8(16'h5a5a));
        $display("buffer test done");
    endtask
    initial begin
        repeat (16) @(negedge clk_in);
        srst_in = 1'b0;
        t_pwrup();
        t_cmd_read();
        t_write();
        t_full();
        results();
    end
endmodule
